// >>> rtl/asf_status_word.sv
// Purpose: ALU condition word with APB access, flag updates and priority level.
// Assumes: ALU, repeat sequencer and interrupt logic run on clk.
// Notes: One register; hardware updates beat a software write bit by bit.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "asf_status_map.svh"
module asf_status_word
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic [`ASF_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ALU datapath
  input asf_alu_op_t aluOp,
  // Repeat loop sequencer
  input wire logic repeatLoopActive,
  // Interrupt priority logic
  input wire logic hwLevelWrite,
  input wire logic [2:0] hwLevel,
  input wire logic priorityLevelHighBit,
  // Status out
  output asf_status_t aluConditionWord,
  output logic [3:0] effectiveLevel,
  output logic userIrqMasked
);

  // Flag results and next word
  asf_flags_t calcFlags; // Flags of the current ALU operation
  asf_status_t next_word; // Next condition word
  // Bus slave state and registered answer
  asf_apb_state_t apbState; // Bus slave state
  asf_apb_state_t next_apbState;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  // Write decode
  logic addrHit; // Address selects the condition word
  logic wrCommit; // Software write takes effect this edge
  logic [15:0] wrMask; // Bits a software write may change
  logic [15:0] wrWord; // Word after software write merge

  // Flag arithmetic
  asf_flag_calc #(
    .WIDTH(16)
  ) u_calc (
    .aluOp(aluOp),
    .flags(calcFlags)
  );

  // Effective priority level and user mask
  asf_prio_level u_level (
    .clk(clk),
    .resetn(resetn),
    .cpuPriorityLevel(aluConditionWord.cpuPriorityLevel),
    .priorityLevelHighBit(priorityLevelHighBit),
    .effectiveLevel(effectiveLevel),
    .userIrqMasked(userIrqMasked)
  );

  // Decode and write strobe; writes land only on the edge that samples pready
  always_comb begin
    addrHit = (paddr == `ASF_COND_WORD_OFFSET);
    wrCommit = psel && penable && pready && pwrite && addrHit;
    // Lane 0 covers bits 7:0 and lane 1 bit 8; lanes 2 and 3 have nothing behind them
    wrMask = `ASF_COND_WORD_WMASK & {{8{pstrb[1]}}, {8{pstrb[0]}}};
    // Bits outside the mask keep their value, so the repeat flag cannot be written
    wrWord = (aluConditionWord & ~wrMask) | (pwdata[15:0] & wrMask);
  end

  // Next condition word: software first, then hardware over it
  always_comb begin
    next_word = aluConditionWord;
    if (wrCommit) begin
      next_word = asf_status_t'(wrWord);
    end
    if (aluOp.valid) begin
      // Hardware written last so it wins a same-cycle write
      // Half carry: nibble carry for bytes, byte carry for words
      if (aluOp.update.halfCarry) begin
        next_word.halfCarryFlag = calcFlags.halfCarry;
      end
      // Sign of the result at the operand size
      if (aluOp.update.negative) begin
        next_word.negative = calcFlags.negative;
      end
      // Signed overflow: like-signed operands, result of the other sign
      if (aluOp.update.overflow) begin
        next_word.signedOverflowFlag = calcFlags.overflow;
      end
      // Carry out of the top bit; for subtract it means no borrow
      if (aluOp.update.carry) begin
        next_word.carry = calcFlags.carry;
      end
      if (aluOp.update.zero) begin
        // Chained ops keep an earlier clear; a nonzero result always clears
        if (aluOp.stickyZero) begin
          next_word.zero = aluConditionWord.zero & calcFlags.zero;
        end else begin
          next_word.zero = calcFlags.zero;
        end
      end
    end
    // Interrupt logic loads a new level; it too beats a software write
    if (hwLevelWrite) begin
      next_word.cpuPriorityLevel = hwLevel;
    end
    // Repeat flag tracks the sequencer only; writes cannot reach it
    next_word.repeatLoopFlag = repeatLoopActive;
    next_word.unused = 7'h00;
  end

  // Condition word register, cleared at reset
  // No enable: the next-value logic holds the word when nothing updates it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aluConditionWord <= asf_status_t'(`ASF_COND_WORD_RESET);
    end else begin
      aluConditionWord <= next_word;
    end
  end

  // APB answer: one wait state so read data come from a flop
  always_comb begin
    next_apbState = ASF_APB_IDLE;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    case (apbState)
      ASF_APB_IDLE: begin
        if (psel && penable) begin
          // Access phase seen: answer on the next edge, whatever the address
          next_apbState = ASF_APB_ANSWER;
          next_pready = 1'b1;
          next_pslverr = !addrHit;
          // Unmapped or write access reads back zero
          next_prdata = (addrHit && !pwrite) ? {16'h0000, aluConditionWord} : 32'h0000_0000;
        end
      end
      ASF_APB_ANSWER: begin
        // Drop pready; a new setup may follow at once
        next_apbState = ASF_APB_IDLE;
      end
      default: begin
        next_apbState = ASF_APB_IDLE;
      end
    endcase
  end

  // Bus slave registers
  // pready is high for exactly one cycle; pslverr rises and falls with it only for an unmapped access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      apbState <= ASF_APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      apbState <= next_apbState;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Reference arithmetic read only by the checks below
  // Only plain adds are checked here; subtract and carry-in paths are left to the bench model
  logic plainAdd; // Add without carry in or inversion
  logic [16:0] refSum;
  logic [4:0] refNib;
  logic [8:0] refByte;
  always_comb begin
    plainAdd = aluOp.valid && !aluOp.subtract && !aluOp.carryIn;
    refSum = {1'b0, aluOp.opA} + {1'b0, aluOp.opB};
    refNib = {1'b0, aluOp.opA[3:0]} + {1'b0, aluOp.opB[3:0]};
    refByte = {1'b0, aluOp.opA[7:0]} + {1'b0, aluOp.opB[7:0]};
  end

  // All checks run on clk and are off while reset is held
  // Flags show one edge after the op, so most checks look back one cycle
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  half_carry_a: assert property (
    plainAdd && aluOp.update.halfCarry |=>
    aluConditionWord.halfCarryFlag == ($past(aluOp.isByte) ? $past(refNib[4]) : $past(refByte[8])))
    else $error("half carry flag wrong");

  level_field_a: assert property (
    hwLevelWrite |=> aluConditionWord.cpuPriorityLevel == $past(hwLevel) ##1
    userIrqMasked == (aluConditionWord.cpuPriorityLevel == 3'h7 && $past(hwLevel) == 3'h7) ||
    (userIrqMasked && $past(hwLevel, 2) == 3'h7))
    else $error("priority field or user mask wrong");

  eff_level_a: assert property (
    ##1 effectiveLevel == {$past(priorityLevelHighBit), $past(aluConditionWord.cpuPriorityLevel)})
    else $error("effective level wrong");

  repeat_flag_a: assert property (
    wrCommit && pwdata[4] && !repeatLoopActive |=> !aluConditionWord.repeatLoopFlag)
    else $error("repeat flag written by software");

  negative_a: assert property (
    plainAdd && !aluOp.isByte && aluOp.update.negative |=> aluConditionWord.negative == $past(refSum[15]))
    else $error("negative flag wrong");

  overflow_a: assert property (
    plainAdd && !aluOp.isByte && aluOp.update.overflow |=>
    aluConditionWord.signedOverflowFlag ==
    $past((aluOp.opA[15] == aluOp.opB[15]) && (refSum[15] != aluOp.opA[15])))
    else $error("overflow flag wrong");

  zero_clear_a: assert property (
    plainAdd && !aluOp.isByte && aluOp.update.zero && refSum[15:0] != 16'h0000 |=> !aluConditionWord.zero)
    else $error("zero flag not cleared by nonzero result");

  carry_a: assert property (
    plainAdd && !aluOp.isByte && aluOp.update.carry |=> aluConditionWord.carry == $past(refSum[16]))
    else $error("carry flag wrong");

  reserved_zero_a: assert property (
    pready |-> prdata[31:9] == 23'h000000 && aluConditionWord.unused == 7'h00)
    else $error("unimplemented bits not zero");

  sw_write_a: assert property (
    wrCommit && pstrb[0] && !aluOp.valid && !hwLevelWrite |=>
    aluConditionWord.carry == $past(pwdata[0]) && aluConditionWord.negative == $past(pwdata[3]))
    else $error("software write lost");

  hw_wins_a: assert property (
    wrCommit && aluOp.valid && aluOp.update.carry |=> aluConditionWord.carry == $past(calcFlags.carry))
    else $error("software write beat hardware");

  apb_answer_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

  word_carry_c: cover property (plainAdd && !aluOp.isByte && refSum[16]);
  byte_half_c: cover property (plainAdd && aluOp.isByte && refNib[4]);
  sw_write_c: cover property (wrCommit);
  unmapped_c: cover property (pready && pslverr);
  sticky_zero_c: cover property (aluOp.valid && aluOp.stickyZero && aluOp.update.zero && aluConditionWord.zero);

  // Byte operations take their flags from the low byte, bit 7 being the sign
  byte_carry_a: assert property (
    plainAdd && aluOp.isByte && aluOp.update.carry |=> aluConditionWord.carry == $past(refByte[8]))
    else $error("byte carry flag wrong");

  byte_negative_a: assert property (
    plainAdd && aluOp.isByte && aluOp.update.negative |=> aluConditionWord.negative == $past(refByte[7]))
    else $error("byte negative flag wrong");

  byte_overflow_a: assert property (
    plainAdd && aluOp.isByte && aluOp.update.overflow |=>
    aluConditionWord.signedOverflowFlag ==
    $past((aluOp.opA[7] == aluOp.opB[7]) && (refByte[7] != aluOp.opA[7])))
    else $error("byte overflow flag wrong");

  byte_zero_a: assert property (
    plainAdd && aluOp.isByte && aluOp.update.zero && !aluOp.stickyZero |=>
    aluConditionWord.zero == $past(refByte[7:0] == 8'h00))
    else $error("byte zero flag wrong");

  // A plain op sets the zero flag on a zero result; a chained op can only clear it
  zero_set_a: assert property (
    plainAdd && !aluOp.isByte && aluOp.update.zero && !aluOp.stickyZero &&
    refSum[15:0] == 16'h0000 |=> aluConditionWord.zero)
    else $error("zero flag not set by zero result");

  sticky_keep_a: assert property (
    aluOp.valid && aluOp.update.zero && aluOp.stickyZero && !aluConditionWord.zero |=> !aluConditionWord.zero)
    else $error("chained op set the zero flag");

  // The repeat flag is a one-edge copy of the sequencer, whatever software writes
  repeat_follow_a: assert property (
    1'b1 |=> aluConditionWord.repeatLoopFlag == $past(repeatLoopActive))
    else $error("repeat flag does not follow the sequencer");

  // The user mask follows the stored field one edge late
  mask_seven_a: assert property (
    1'b1 |=> userIrqMasked == ($past(aluConditionWord.cpuPriorityLevel) == 3'h7))
    else $error("user mask does not follow level seven");

  // Read data are the word as it stood when the access phase began
  read_data_a: assert property (
    psel && penable && !pready && addrHit && !pwrite |=> prdata[15:0] == $past(aluConditionWord))
    else $error("read data wrong");

  // Unmapped accesses answer with an error and zero data
  unmapped_err_a: assert property (
    psel && penable && !pready && !addrHit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // A write with lane 1 off leaves bit 8 alone unless an op updates it
  lane_keep_a: assert property (
    wrCommit && !pstrb[1] && !(aluOp.valid && aluOp.update.halfCarry) |=>
    $stable(aluConditionWord.halfCarryFlag))
    else $error("write reached bit 8 with its lane off");

  // pready rises only after an access phase, and read data change only with it
  ready_cause_a: assert property (
    !(psel && penable) |=> !pready)
    else $error("pready without an access");

  data_hold_a: assert property (
    1'b1 |=> pready || $stable(prdata))
    else $error("read data changed without an answer");

endmodule // asf_status_word

// >>> rtl/asf_status_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the ALU condition word.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef ASF_STATUS_MAP_SVH
`define ASF_STATUS_MAP_SVH

// Register offset and address width
`define ASF_ADDR_W 12
`define ASF_COND_WORD_OFFSET 12'h000

// Field positions inside the condition word
`define ASF_BIT_CARRY 0
`define ASF_BIT_ZERO 1
`define ASF_BIT_OVERFLOW 2
`define ASF_BIT_NEGATIVE 3
`define ASF_BIT_REPEAT 4
`define ASF_BIT_LEVEL_LO 5
`define ASF_BIT_LEVEL_HI 7
`define ASF_BIT_HALF_CARRY 8

// Reset value and software-writable bits (repeat flag and bits 15..9 excluded)
`define ASF_COND_WORD_RESET 16'h0000
`define ASF_COND_WORD_WMASK 16'h01EF
`define ASF_LEVEL_ALL_MASKED 3'h7

// Answer latency of the bus slave, in clock cycles after the access phase starts
`define ASF_APB_WAIT_CYCLES 1

`endif

// >>> rtl/asf_pkg.sv
// Purpose: Types shared by the ALU condition word design.
// Assumes: 16-bit datapath.
// Notes: Numbers live in asf_status_map.svh.
package asf_pkg;

  // Stored condition word, bit 15 down to bit 0
  typedef struct packed {
    logic [6:0] unused;
    logic halfCarryFlag;
    logic [2:0] cpuPriorityLevel;
    logic repeatLoopFlag;
    logic negative;
    logic signedOverflowFlag;
    logic zero;
    logic carry;
  } asf_status_t;

  // Flags computed for one ALU operation, or which of them it updates
  typedef struct packed {
    logic halfCarry;
    logic negative;
    logic overflow;
    logic zero;
    logic carry;
  } asf_flags_t;

  // One ALU operation as seen by the flag logic
  typedef struct packed {
    logic valid;
    logic isByte;
    logic subtract;
    logic carryIn;
    logic stickyZero;
    asf_flags_t update;
    logic [15:0] opA;
    logic [15:0] opB;
  } asf_alu_op_t;

  // Bus slave states
  typedef enum logic {ASF_APB_IDLE, ASF_APB_ANSWER} asf_apb_state_t;

endpackage

// >>> rtl/asf_flag_calc.sv
// Purpose: Computes carry, half carry, negative, overflow and zero for one ALU operation.
// Assumes: Subtraction is A + ~B + carryIn, so carry set means no borrow.
// Notes: Purely combinational; the caller registers the flags.
`timescale 1ns/1ps
`include "asf_status_map.svh"
module asf_flag_calc
  import asf_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Operation in
  input asf_alu_op_t aluOp,
  // Flags out
  output asf_flags_t flags
);

  // Only the 16-bit datapath is served
  if (WIDTH != 16) begin : bad_width
    $error("asf_flag_calc serves WIDTH 16 only");
  end

  logic [15:0] effB; // Second operand after inversion for subtract
  logic [16:0] wordSum; // Full-width sum with carry out
  logic [4:0] nibbleSum; // Low nibble sum, bit 4 is half carry for bytes
  logic [8:0] byteSum; // Low byte sum, bit 8 is byte carry

  // Adder chains
  always_comb begin
    effB = aluOp.subtract ? ~aluOp.opB : aluOp.opB;
    wordSum = {1'b0, aluOp.opA} + {1'b0, effB} + {16'h0000, aluOp.carryIn};
    nibbleSum = {1'b0, aluOp.opA[3:0]} + {1'b0, effB[3:0]} + {4'h0, aluOp.carryIn};
    byteSum = {1'b0, aluOp.opA[7:0]} + {1'b0, effB[7:0]} + {8'h00, aluOp.carryIn};
  end

  // Flag selection by operand size
  always_comb begin
    if (aluOp.isByte) begin
      flags.halfCarry = nibbleSum[4];
      flags.carry = byteSum[8];
      flags.negative = byteSum[7];
      flags.overflow = (aluOp.opA[7] == effB[7]) && (byteSum[7] != aluOp.opA[7]);
      flags.zero = (byteSum[7:0] == 8'h00);
    end else begin
      flags.halfCarry = byteSum[8];
      flags.carry = wordSum[16];
      flags.negative = wordSum[15];
      flags.overflow = (aluOp.opA[15] == effB[15]) && (wordSum[15] != aluOp.opA[15]);
      flags.zero = (wordSum[15:0] == 16'h0000);
    end
  end

endmodule // asf_flag_calc

// >>> rtl/asf_prio_level.sv
// Purpose: Forms the four-bit effective CPU priority level.
// Assumes: High bit comes from core control logic on the same clock.
// Notes: Outputs are registered, so they lag the inputs by one edge.
`timescale 1ns/1ps
`include "asf_status_map.svh"
module asf_prio_level (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Level sources
  input wire logic [2:0] cpuPriorityLevel,
  input wire logic priorityLevelHighBit,
  // Level out
  output logic [3:0] effectiveLevel,
  output logic userIrqMasked
);

  logic [3:0] next_effectiveLevel; // Joined level
  logic next_userIrqMasked; // Level 7 of the field masks user sources

  // Join the high bit above the three status bits
  always_comb begin
    next_effectiveLevel = {priorityLevelHighBit, cpuPriorityLevel};
    next_userIrqMasked = (cpuPriorityLevel == `ASF_LEVEL_ALL_MASKED);
  end

  // Register the level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      effectiveLevel <= 4'h0;
      userIrqMasked <= 1'b0;
    end else begin
      effectiveLevel <= next_effectiveLevel;
      userIrqMasked <= next_userIrqMasked;
    end
  end

endmodule // asf_prio_level

// >>> verif/asf_alu_partner.sv
// Purpose: Far-side model of the ALU datapath, repeat sequencer and priority logic.
// Assumes: Called from the bench; every change lands by NBA right after a rising edge.
// Notes: Holds each value until told otherwise, as the real sources do.
`timescale 1ns/1ps
module asf_alu_partner
  import asf_pkg::*;
(
  // Clock
  input wire logic clk,
  // ALU datapath side
  output asf_alu_op_t aluOp,
  // Repeat sequencer side
  output logic repeatLoopActive,
  // Priority logic side
  output logic hwLevelWrite,
  output logic [2:0] hwLevel,
  output logic priorityLevelHighBit
);
  // Idle values from time zero
  initial begin
    aluOp = '0;
    repeatLoopActive = 1'h0;
    hwLevelWrite = 1'h0;
    hwLevel = 3'h0;
    priorityLevelHighBit = 1'h0;
  end

  // Present an op now; the caller already stands on a rising edge
  task automatic setOp(input asf_alu_op_t op);
    aluOp <= op;
  endtask

  // Present an op after the next edge; back-to-back calls give one op a cycle
  task automatic issue(input asf_alu_op_t op);
    @(posedge clk);
    aluOp <= op;
  endtask

  // Repeat loop start or end
  task automatic setRepeat(input logic r);
    @(posedge clk);
    repeatLoopActive <= r;
  endtask

  // One-cycle level load; the high bit stays as a level
  task automatic setLevel(input logic [2:0] lev, input logic hi);
    @(posedge clk);
    hwLevelWrite <= 1'h1;
    hwLevel <= lev;
    priorityLevelHighBit <= hi;
    @(posedge clk);
    hwLevelWrite <= 1'h0;
  endtask
endmodule // asf_alu_partner

// >>> verif/asf_status_word_tb.sv
// Purpose: Self-checking bench for the ALU condition word.
// Assumes: One wait state on APB, flags visible one edge after an op.
// Notes: Expected word is tracked by a bench model, never read back from the design.
`timescale 1ns/1ps
`include "asf_status_map.svh"
module asf_status_word_tb
  import asf_pkg::*;
;
  logic clk = 1'h0; // 200 MHz core clock
  logic resetn;
  // APB master side
  logic [11:0] paddr;
  logic psel, penable, pwrite;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic pready, pslverr, err;
  // Partner and status
  asf_alu_op_t aluOp, op;
  asf_alu_op_t corners[6];
  logic repeatLoopActive, hwLevelWrite, priorityLevelHighBit, userIrqMasked;
  logic [2:0] hwLevel;
  logic [3:0] effectiveLevel;
  asf_status_t aluConditionWord, exp;
  int n_errors = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  asf_status_word asf_status_word_inst (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aluOp(aluOp), .repeatLoopActive(repeatLoopActive), .hwLevelWrite(hwLevelWrite),
    .hwLevel(hwLevel), .priorityLevelHighBit(priorityLevelHighBit), .aluConditionWord(aluConditionWord),
    .effectiveLevel(effectiveLevel), .userIrqMasked(userIrqMasked));
  asf_alu_partner asf_alu_partner_inst (.clk(clk), .aluOp(aluOp), .repeatLoopActive(repeatLoopActive),
    .hwLevelWrite(hwLevelWrite), .hwLevel(hwLevel), .priorityLevelHighBit(priorityLevelHighBit));

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string msg);
    tests_run++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, want);
    end
  endtask

  // One APB transfer; op is held on the ALU side for the whole transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input asf_alu_op_t o);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    asf_alu_partner_inst.setOp(o);
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    // A slave that never answers ends the run
    if (n >= 50) begin
      n_errors++;
      stop_test();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    asf_alu_partner_inst.setOp('0);
  endtask

  // Software write into the expected word; repeat flag and top bits keep their value
  function automatic asf_status_t swr(input asf_status_t s, input logic [15:0] d);
    return asf_status_t'((s & ~`ASF_COND_WORD_WMASK) | (d & `ASF_COND_WORD_WMASK));
  endfunction

  // Flag model of one op; subtraction is A + ~B + carry in
  function automatic asf_status_t model(input asf_status_t s, input asf_alu_op_t o);
    int w;
    logic [16:0] a, b, sum, hs;
    asf_status_t n;
    n = s;
    if (!o.valid) return s;
    w = o.isByte ? 8 : 16;
    a = o.isByte ? {9'h0, o.opA[7:0]} : {1'h0, o.opA};
    b = o.subtract ? {1'h0, ~o.opB} : {1'h0, o.opB};
    b = o.isByte ? {9'h0, b[7:0]} : b;
    sum = a + b + o.carryIn;
    hs = o.isByte ? a[3:0] + b[3:0] + o.carryIn : a[7:0] + b[7:0] + o.carryIn;
    if (o.update.halfCarry) n.halfCarryFlag = o.isByte ? hs[4] : hs[8];
    if (o.update.negative) n.negative = sum[w-1];
    if (o.update.overflow) n.signedOverflowFlag = (a[w-1] == b[w-1]) && (sum[w-1] != a[w-1]);
    if (o.update.carry) n.carry = sum[w];
    if (o.update.zero) n.zero = (o.stickyZero ? s.zero : 1'h1) & ((sum & ((17'h1 << w) - 1)) == 0);
    return n;
  endfunction

  // Built op with every flag selected
  function automatic asf_alu_op_t mk(input logic ib, sb, ci, sz, input logic [15:0] a, b);
    return {1'h1, ib, sb, ci, sz, 5'h1f, a, b};
  endfunction

  // Random op; operands often equal so zero results turn up
  function automatic asf_alu_op_t randOp();
    logic [31:0] r, q;
    asf_alu_op_t o;
    r = $urandom;
    q = $urandom;
    o = {r[2:0] != 3'h0, r[3], r[4], r[4] & r[5], r[6], r[11:7], r[27:12], q[15:0]};
    if (q[17:16] == 2'h0) o.opB = o.opA;
    return o;
  endfunction

  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    exp = '0;
    void'($urandom(32'hf906_2134));
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    #1 check({16'h0, aluConditionWord}, 32'h0000_0000, "reset word");
    check({28'h0, effectiveLevel}, 32'h0000_0000, "reset level");
    apb(1'h1, 12'h008, 32'hffff_ffff, '0);
    apb(1'h0, 12'h004, 32'h0000_0000, '0);
    check({31'h0, err}, 32'h0000_0001, "unmapped error");
    check({16'h0, aluConditionWord}, 32'h0000_0000, "unmapped write");
    $display("test reset done");
    // All ones written: only the writable bits take them
    apb(1'h1, `ASF_COND_WORD_OFFSET, 32'hffff_ffff, '0);
    exp = swr(exp, 16'hffff);
    apb(1'h0, `ASF_COND_WORD_OFFSET, 32'h0000_0000, '0);
    check(rdata, {16'h0, exp}, "write ones");
    check({31'h0, userIrqMasked}, 32'h0000_0001, "level seven masks");
    // Software cannot clear a running repeat flag
    asf_alu_partner_inst.setRepeat(1'h1);
    apb(1'h1, `ASF_COND_WORD_OFFSET, 32'h0000_0000, '0);
    exp = swr(exp, 16'h0000);
    exp.repeatLoopFlag = 1'h1;
    apb(1'h0, `ASF_COND_WORD_OFFSET, 32'h0000_0000, '0);
    check(rdata, {16'h0, exp}, "repeat read only");
    asf_alu_partner_inst.setRepeat(1'h0);
    exp.repeatLoopFlag = 1'h0;
    @(posedge clk);
    #1 check({16'h0, aluConditionWord}, {16'h0, exp}, "repeat ends");
    $display("test software access done");
    // Every level with both high bit values
    for (int i = 0; i < 16; i++) begin
      asf_alu_partner_inst.setLevel(i[2:0], i[3]);
      exp.cpuPriorityLevel = i[2:0];
      @(posedge clk);
      #1 check({16'h0, aluConditionWord}, {16'h0, exp}, "level field");
      check({28'h0, effectiveLevel}, i, "effective level");
      check({31'h0, userIrqMasked}, {31'h0, i[2:0] == 3'h7}, "mask at seven");
    end
    $display("test levels done");
    // Carry set by hardware while software writes zero
    apb(1'h1, `ASF_COND_WORD_OFFSET, 32'h0000_0000, {1'h1, 9'h001, 16'hffff, 16'h0001});
    exp = swr(exp, 16'h0000);
    exp.carry = 1'h1;
    @(posedge clk);
    #1 check({16'h0, aluConditionWord}, {16'h0, exp}, "hardware wins");
    $display("test collision done");
    // Lane 1 off: bit 8 keeps its value while the low byte takes the write
    pstrb <= 4'h1;
    apb(1'h1, `ASF_COND_WORD_OFFSET, 32'hffff_ffff, '0);
    pstrb <= 4'hf;
    exp = swr(exp, {7'h00, exp.halfCarryFlag, 8'hff});
    apb(1'h0, `ASF_COND_WORD_OFFSET, 32'h0000_0000, '0);
    check(rdata, {16'h0, exp}, "lane one off");
    check({31'h0, err}, 32'h0000_0000, "mapped read");
    $display("test byte lanes done");
    // Corner ops first, then random ones back to back
    corners[0] = mk(1'h0, 1'h0, 1'h0, 1'h0, 16'hffff, 16'h0001);
    corners[1] = mk(1'h1, 1'h0, 1'h0, 1'h0, 16'h007f, 16'h0001);
    corners[2] = mk(1'h0, 1'h0, 1'h0, 1'h1, 16'h00ff, 16'h0001);
    corners[3] = mk(1'h0, 1'h1, 1'h1, 1'h0, 16'h8000, 16'h0001);
    corners[4] = mk(1'h1, 1'h1, 1'h1, 1'h1, 16'h0010, 16'h0010);
    corners[5] = mk(1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h0000);
    for (int i = 0; i < 400; i++) begin
      op = (i < 6) ? corners[i] : randOp();
      asf_alu_partner_inst.issue(op);
      #1 check({16'h0, aluConditionWord}, {16'h0, exp}, "alu flags");
      exp = model(exp, op);
    end
    asf_alu_partner_inst.issue('0);
    #1 check({16'h0, aluConditionWord}, {16'h0, exp}, "last flags");
    $display("test alu flags done");
    stop_test();
  end
endmodule // asf_status_word_tb
